/* hdl/adc_spi_device.sv */
// Overview of operation
// - converter active only while its select low
// - host never selects both chips together
// - mode 1, clock idles low, capture falling
// - four config registers, reserved ones take defaults; the device stores whatever byte the host writes to them
// - write command 0100, index, count minus one
// - index 0 count 3 loads all four
// - commands decoded mid-read without corrupting data
// - commands start only on byte boundaries
// - new settings applied after command, conversion restarts
// - register 1 holds rate, mode, source fields
// - source bit picks pressure or temperature
// - mode field picks normal or fast modulator
// - rate code sets samples per second
// - reset command restores register defaults
// - host powers up with reset then full write
// - power-up bytes come from calibration memory; the host sends its calib_word register instead
// - host needs temperature and pressure readings
// - data starts on rising edge after command; the device shifts it out from the first rising edge of every frame
// - temperature is 14-bit, MSB first, padded
// - pressure is 24-bit two's complement MSB first
module adc_spi_device
    import adc_spi_pkg::*;
#(
    parameter int CLK_HZ = SYS_CLK_HZ
) (
    // system
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // serial link
    adc_spi_if.device        link,
    // conversion front end
    input  wire logic [23:0] pressure_in,
    input  wire logic [13:0] temperature_in,
    // status toward the sense element
    output logic             conv_done,
    output logic             modulator_tick,
    output logic [31:0]      cfg_regs
);
    localparam int TICK_NORMAL = CLK_HZ / MOD_NORMAL_HZ;
    localparam int TICK_FAST   = CLK_HZ / MOD_FAST_HZ;

    if (TICK_FAST < 1) begin : g_chk
        $error("clock too slow for the fast modulator rate");
    end

    typedef enum logic [0:0] {CMD_WAIT, CMD_DATA} cmd_state_t;

    logic [1:0]  cs_s;
    logic [1:0]  sclk_s;
    logic [1:0]  mosi_s;
    logic        sclk_prev;
    logic        selected;
    logic        rise;
    logic        fall;
    logic [2:0]  bit_cnt;
    logic [6:0]  rx_sh;
    logic        byte_done;
    logic [7:0]  rx_byte;
    cmd_state_t  cmd_state;
    logic [2:0]  wr_idx;
    logic [1:0]  wr_left;
    logic [7:0]  cfg [CFG_REG_COUNT];
    logic [7:0]  active_cfg1;
    logic        apply;
    logic        do_reset;
    logic [4:0]  out_cnt;
    logic [23:0] out_sh;
    logic [23:0] result_word;
    logic [9:0]  mod_cnt;
    logic [15:0] conv_cnt;
    logic        fast;
    logic [2:0]  rate;

    // link inputs are asynchronous to clk
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s      <= 2'h3;
            sclk_s    <= 2'h0;
            mosi_s    <= 2'h0;
            sclk_prev <= 1'b0;
        end else begin
            cs_s      <= {cs_s[0], link.adc_select_n};
            sclk_s    <= {sclk_s[0], link.sclk};
            mosi_s    <= {mosi_s[0], link.mosi};
            sclk_prev <= sclk_s[1];
        end
    end

    assign selected  = !cs_s[1];
    assign rise      = selected && sclk_s[1] && !sclk_prev;
    assign fall      = selected && !sclk_s[1] && sclk_prev;
    assign byte_done = fall && (bit_cnt == 3'h7);
    assign rx_byte   = {rx_sh, mosi_s[1]};

    // bytes align to the select edge, so commands sit on 8-bit boundaries
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 7'h00;
        end else if (!selected) begin
            bit_cnt <= 3'h0;
        end else if (fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= {rx_sh[5:0], mosi_s[1]};
        end
    end

    assign do_reset = byte_done && (cmd_state == CMD_WAIT) && (rx_byte == CMD_RESET);
    assign apply    = byte_done && (cmd_state == CMD_DATA) && (wr_left == 2'h0);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_state <= CMD_WAIT;
            wr_idx    <= 3'h0;
            wr_left   <= 2'h0;
        end else if (!selected) begin
            cmd_state <= CMD_WAIT;
        end else if (byte_done) begin
            case (cmd_state)
                CMD_WAIT: begin
                    if (rx_byte[7:4] == CMD_WRITE_OP) begin
                        cmd_state <= CMD_DATA;
                        wr_idx    <= {1'b0, rx_byte[3:2]};
                        wr_left   <= rx_byte[1:0];
                    end
                end
                CMD_DATA: begin
                    wr_idx  <= wr_idx + 3'h1;
                    wr_left <= wr_left - 2'h1;
                    if (wr_left == 2'h0) begin
                        cmd_state <= CMD_WAIT;
                    end
                end
                default: cmd_state <= CMD_WAIT;
            endcase
        end
    end

    // reserved registers take their defaults on reset, otherwise whatever byte the host sends
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg[0] <= CFG0_RESET;
            cfg[1] <= CFG1_RESET;
            cfg[2] <= CFG2_RESET;
            cfg[3] <= CFG3_RESET;
        end else if (do_reset) begin
            cfg[0] <= CFG0_RESET;
            cfg[1] <= CFG1_RESET;
            cfg[2] <= CFG2_RESET;
            cfg[3] <= CFG3_RESET;
        end else if (byte_done && (cmd_state == CMD_DATA) && !wr_idx[2]) begin
            cfg[wr_idx[1:0]] <= rx_byte;
        end
    end

    assign cfg_regs = {cfg[3], cfg[2], cfg[1], cfg[0]};

    // settings take effect only once the whole command is in
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_cfg1 <= CFG1_RESET;
        end else if (do_reset) begin
            active_cfg1 <= CFG1_RESET;
        end else if (apply) begin
            active_cfg1 <= (wr_idx == 3'h1) ? rx_byte : cfg[1];
        end
    end

    assign fast = (active_cfg1[MODE_MSB:MODE_LSB] == MODE_FAST);
    assign rate = (active_cfg1[RATE_MSB:RATE_LSB] == RATE_UNUSED) ? 3'h0
                : active_cfg1[RATE_MSB:RATE_LSB];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mod_cnt        <= 10'h000;
            modulator_tick <= 1'b0;
        end else if (mod_cnt >= 10'(fast ? TICK_FAST - 1 : TICK_NORMAL - 1)) begin
            mod_cnt        <= 10'h000;
            modulator_tick <= 1'b1;
        end else begin
            mod_cnt        <= mod_cnt + 10'h001;
            modulator_tick <= 1'b0;
        end
    end

    // same tick count serves both modes, the fast tick doubles the rate
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_cnt    <= 16'h0000;
            conv_done   <= 1'b0;
            result_word <= 24'h000000;
        end else if (apply || do_reset) begin
            conv_cnt  <= 16'h0000;
            conv_done <= 1'b0;
        end else if (modulator_tick && (conv_cnt >= 16'(conv_ticks(rate) - 1))) begin
            conv_cnt  <= 16'h0000;
            conv_done <= 1'b1;
            if (active_cfg1[SRC_BIT]) begin
                result_word <= {temperature_in, 10'h000};
            end else begin
                result_word <= pressure_in;
            end
        end else begin
            conv_cnt  <= conv_cnt + 16'(modulator_tick);
            conv_done <= 1'b0;
        end
    end

    // the word is captured whole at the frame start, so commands
    // arriving later in the frame cannot disturb it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_cnt        <= 5'h00;
            out_sh         <= 24'h000000;
            link.dout      <= 1'b0;
            link.dout_en_n <= 1'b1;
        end else begin
            link.dout_en_n <= !selected;
            if (!selected) begin
                out_cnt <= 5'h00;
            end else if (rise) begin
                out_cnt <= out_cnt + 5'h01;
                if (out_cnt == 5'h00) begin
                    link.dout <= result_word[WORD_BITS-1];
                    out_sh    <= {result_word[WORD_BITS-2:0], 1'b0};
                end else begin
                    link.dout <= out_sh[WORD_BITS-1];
                    out_sh    <= {out_sh[WORD_BITS-2:0], 1'b0};
                end
            end
        end
    end
endmodule : adc_spi_device

/* hdl/adc_spi_host.sv */
module adc_spi_host
    import adc_spi_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
    // system
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // serial link
    adc_spi_if.host          link
);
    if (HALF_CYCLES < 4) begin : g_chk
        $error("serial clock half period too short for the converter");
    end

    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TRAIL} host_state_t;

    host_state_t state;
    logic [15:0] div;
    logic        div_hit;
    logic [1:0]  miso_s;
    logic [63:0] tx_buf;
    logic [6:0]  bits_left;
    logic [23:0] rx_sh;
    logic [4:0]  rx_cnt;
    logic        keep_word;
    logic        frame_src;
    logic [1:0]  end_op;
    logic        active_src;
    logic [7:0]  cfg1_value;
    logic [31:0] calib_word;
    logic [23:0] pres_word;
    logic [23:0] temp_word;
    logic        pres_valid;
    logic        temp_valid;
    logic        wr_take;
    logic [31:0] wmask;
    logic [2:0]  go;
    logic        busy;

    assign busy    = (state != H_IDLE);
    assign wr_take = awvalid && wvalid && !bvalid;
    assign awready = wr_take;
    assign wready  = wr_take;
    assign arready = !rvalid;
    assign wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    assign go      = (wr_take && (awaddr == OFS_CTRL) && wstrb[0] && !busy)
                   ? wdata[2:0] : 3'h0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid     <= 1'b0;
            bresp      <= RESP_OKAY;
            cfg1_value <= HOST_CFG1_RESET;
            calib_word <= CALIB_RESET;
        end else if (wr_take) begin
            bvalid <= 1'b1;
            bresp  <= RESP_OKAY;
            case (awaddr)
                OFS_CTRL:  ;
                OFS_CFG1:  cfg1_value <= (cfg1_value & ~wmask[7:0]) | (wdata[7:0] & wmask[7:0]);
                OFS_CALIB: calib_word <= (calib_word & ~wmask) | (wdata & wmask);
                default:   bresp <= RESP_SLVERR;
            endcase
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (araddr)
                OFS_CTRL:        rdata <= 32'h0000_0000;
                OFS_CFG1:        rdata <= {24'h000000, cfg1_value};
                OFS_CALIB:       rdata <= calib_word;
                OFS_STATUS:      rdata <= {27'h0000000, active_src,
                                           pres_valid && temp_valid,
                                           temp_valid, pres_valid, busy};
                OFS_PRESSURE:    rdata <= {8'h00, pres_word};
                OFS_TEMPERATURE: rdata <= {8'h00, temp_word};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // returned data is asynchronous to clk at the pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            miso_s <= 2'h3;
        end else begin
            miso_s <= {miso_s[0], link.miso};
        end
    end

    assign div_hit = (div == 16'(HALF_CYCLES - 1));

    // calibration memory stays deselected, so the two selects never overlap
    assign link.calib_memory_select_n = 1'b1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state             <= H_IDLE;
            div               <= 16'h0000;
            tx_buf            <= 64'h0;
            bits_left         <= 7'h00;
            rx_sh             <= 24'h000000;
            rx_cnt            <= 5'h00;
            keep_word         <= 1'b0;
            frame_src         <= 1'b0;
            end_op            <= 2'h0;
            link.adc_select_n <= 1'b1;
            link.sclk         <= 1'b0;
            link.mosi         <= 1'b0;
        end else begin
            div <= (state == H_IDLE || div_hit) ? 16'h0000 : div + 16'h0001;
            case (state)
                H_IDLE: begin
                    rx_cnt    <= 5'h00;
                    frame_src <= active_src;
                    if (go[CTRL_INIT_BIT]) begin
                        tx_buf    <= {CMD_RESET, CMD_WRITE_ALL, calib_word[7:0],
                                      calib_word[15:8], calib_word[23:16],
                                      calib_word[31:24], FILL_BYTE, FILL_BYTE};
                        bits_left <= 7'd64;
                        keep_word <= 1'b0;
                        end_op    <= 2'h1;
                        state     <= H_LEAD;
                        link.adc_select_n <= 1'b0;
                    end else if (go[CTRL_CFG_BIT]) begin
                        tx_buf    <= {CMD_WRITE_CFG1, cfg1_value, 48'h0};
                        bits_left <= 7'd32;
                        keep_word <= 1'b1;
                        end_op    <= 2'h2;
                        state     <= H_LEAD;
                        link.adc_select_n <= 1'b0;
                    end else if (go[CTRL_READ_BIT]) begin
                        tx_buf    <= 64'h0;
                        bits_left <= 7'd32;
                        keep_word <= 1'b1;
                        end_op    <= 2'h0;
                        state     <= H_LEAD;
                        link.adc_select_n <= 1'b0;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (div_hit) begin
                        if (bits_left == 7'h00) begin
                            state <= H_TRAIL;
                        end else begin
                            link.sclk <= 1'b1;
                            link.mosi <= tx_buf[63];
                            tx_buf    <= {tx_buf[62:0], 1'b0};
                            state     <= H_HIGH;
                        end
                    end
                end
                H_HIGH: begin
                    if (div_hit) begin
                        link.sclk <= 1'b0;
                        bits_left <= bits_left - 7'h01;
                        if (rx_cnt < 5'(WORD_BITS)) begin
                            rx_sh  <= {rx_sh[22:0], miso_s[1]};
                            rx_cnt <= rx_cnt + 5'h01;
                        end
                        state <= H_LOW;
                    end
                end
                H_TRAIL: begin
                    if (div_hit) begin
                        link.adc_select_n <= 1'b1;
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // a word read while a source change is sent still belongs to the old source
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pres_word  <= 24'h000000;
            temp_word  <= 24'h000000;
            pres_valid <= 1'b0;
            temp_valid <= 1'b0;
            active_src <= 1'b0;
        end else if (state == H_TRAIL && div_hit) begin
            if (keep_word && frame_src) begin
                temp_word  <= rx_sh;
                temp_valid <= 1'b1;
            end else if (keep_word) begin
                pres_word  <= rx_sh;
                pres_valid <= 1'b1;
            end
            if (end_op == 2'h1) begin
                active_src <= calib_word[8+SRC_BIT];
            end else if (end_op == 2'h2) begin
                active_src <= cfg1_value[SRC_BIT];
            end
        end
    end
endmodule : adc_spi_host

/* hdl/adc_spi_if.sv */
interface adc_spi_if;
    logic adc_select_n;
    logic calib_memory_select_n;
    logic sclk;
    logic mosi;
    logic dout;
    logic dout_en_n;
    logic miso;

    // idle line reads high when the converter releases it
    assign miso = dout_en_n ? 1'b1 : dout;

    modport device (
        input  adc_select_n,
        input  sclk,
        input  mosi,
        output dout,
        output dout_en_n
    );
    modport host (
        output adc_select_n,
        output calib_memory_select_n,
        output sclk,
        output mosi,
        input  miso
    );
endinterface : adc_spi_if

/* hdl/adc_spi_pkg.sv */
package adc_spi_pkg;
    // converter side
    localparam int          CFG_REG_COUNT   = 4;
    localparam logic [7:0]  CMD_RESET       = 8'h06;
    localparam logic [3:0]  CMD_WRITE_OP    = 4'h4;
    localparam logic [7:0]  CMD_WRITE_ALL   = 8'h43;
    localparam logic [7:0]  CMD_WRITE_CFG1  = 8'h44;
    localparam logic [7:0]  FILL_BYTE       = 8'h00;
    localparam int          RATE_MSB        = 7;
    localparam int          RATE_LSB        = 5;
    localparam int          MODE_MSB        = 4;
    localparam int          MODE_LSB        = 3;
    localparam int          SRC_BIT         = 1;
    localparam logic [1:0]  MODE_FAST       = 2'h2;
    localparam logic [2:0]  RATE_UNUSED     = 3'h7;
    localparam logic [7:0]  CFG0_RESET      = 8'h00;
    localparam logic [7:0]  CFG1_RESET      = 8'h04;
    localparam logic [7:0]  CFG2_RESET      = 8'h00;
    localparam logic [7:0]  CFG3_RESET      = 8'h00;
    localparam int          FRAME_BITS      = 32;
    localparam int          WORD_BITS       = 24;
    localparam int          TEMP_BITS       = 14;
    localparam int          SYS_CLK_HZ      = 200_000_000;
    localparam int          MOD_NORMAL_HZ   = 256_000;
    localparam int          MOD_FAST_HZ     = 512_000;
    // host side
    localparam int          SCLK_HALF_CYCLES = 16;
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_CFG1        = 8'h04;
    localparam logic [7:0]  OFS_CALIB       = 8'h08;
    localparam logic [7:0]  OFS_STATUS      = 8'h0C;
    localparam logic [7:0]  OFS_PRESSURE    = 8'h10;
    localparam logic [7:0]  OFS_TEMPERATURE = 8'h14;
    localparam int          CTRL_INIT_BIT   = 0;
    localparam int          CTRL_READ_BIT   = 1;
    localparam int          CTRL_CFG_BIT    = 2;
    localparam logic [7:0]  HOST_CFG1_RESET = 8'h04;
    localparam logic [31:0] CALIB_RESET     = 32'h0000_0400;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // modulator ticks per conversion; fast mode doubles both clock and rate
    function automatic int conv_ticks(input logic [2:0] rate);
        case (rate)
            3'h0:    conv_ticks = MOD_NORMAL_HZ / 20;
            3'h1:    conv_ticks = MOD_NORMAL_HZ / 45;
            3'h2:    conv_ticks = MOD_NORMAL_HZ / 90;
            3'h3:    conv_ticks = MOD_NORMAL_HZ / 175;
            3'h4:    conv_ticks = MOD_NORMAL_HZ / 330;
            3'h5:    conv_ticks = MOD_NORMAL_HZ / 600;
            3'h6:    conv_ticks = MOD_NORMAL_HZ / 1000;
            default: conv_ticks = MOD_NORMAL_HZ / 20;
        endcase
    endfunction : conv_ticks
endpackage : adc_spi_pkg

/* test/adc_spi_assertions.sv */
module adc_spi_assertions (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // serial link
    input wire logic adc_select_n,
    input wire logic calib_memory_select_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic dout,
    input wire logic dout_en_n
);
    timeunit 1ns / 1ps;
    logic [7:0] rises;
    logic       sclk_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    // clock rises since select fell, gives the frame position
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) rises <= 8'h00;
        else if (adc_select_n) rises <= 8'h00;
        else if (sclk && !sclk_q) rises <= rises + 8'h01;
    property p_sel; !(!adc_select_n && !calib_memory_select_n); endproperty
    property p_idle; adc_select_n |-> !sclk; endproperty
    property p_stby; adc_select_n [*6] |-> dout_en_n; endproperty
    property p_en; $fell(adc_select_n) |-> ##[1:8] !dout_en_n; endproperty
    property p_mosi; $fell(sclk) |-> $stable(mosi); endproperty
    property p_dout; $fell(sclk) && !dout_en_n |-> $stable(dout); endproperty
    property p_byte; $rose(adc_select_n) |-> rises[2:0] == 3'h0; endproperty
    property p_pad; $fell(sclk) && !dout_en_n && rises[4:0] > 5'h18 |-> !dout; endproperty
    a_sel: assert property (p_sel) else $error("both selects low");
    a_idle: assert property (p_idle) else $error("clock not idle");
    a_stby: assert property (p_stby) else $error("driven in standby");
    a_en: assert property (p_en) else $error("no drive when selected");
    a_mosi: assert property (p_mosi) else $error("mosi moved at capture");
    a_dout: assert property (p_dout) else $error("dout moved at capture");
    a_byte: assert property (p_byte) else $error("frame off byte boundary");
    a_pad: assert property (p_pad) else $error("pad bit not zero");
    cover property ($fell(adc_select_n));
    cover property ($rose(adc_select_n) && rises == 8'h40);
    cover property ($fell(sclk) && !dout_en_n && dout);
endmodule : adc_spi_assertions

/* test/tb_sensor_adc_spi_command_port.sv */
module tb_sensor_adc_spi_command_port;
    import adc_spi_pkg::*;
    timeunit 1ns / 1ps;
    localparam logic [23:0] P1 = 24'h9A5C31;
    localparam logic [23:0] P2 = 24'h13579B;
    // 1000 and 2000 samples per second at the 2.56 MHz CLK_HZ given to the device
    localparam int          PERIOD_NORMAL = 2560;
    localparam int          PERIOD_FAST   = 1280;
    logic        clk;
    logic        sys_rst = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, conv_done;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, cfg_regs, d;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, r;
    logic [23:0] pressure_in = P1;
    logic [13:0] temperature_in = 14'h3CE0;
    int          n_mismatch = 0, checked = 0;
    int          n_cyc;
    adc_spi_if adc_spi_if_i ();
    adc_spi_host adc_spi_host_i (.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .link(adc_spi_if_i));
    // short modulator tick keeps conversions within the run
    adc_spi_device #(.CLK_HZ(2_560_000)) adc_spi_device_i (.clk, .sys_rst,
        .link(adc_spi_if_i), .pressure_in, .temperature_in, .conv_done,
        .modulator_tick(), .cfg_regs);
    adc_spi_assertions adc_spi_assertions_i (.clk, .sys_rst,
        .adc_select_n(adc_spi_if_i.adc_select_n),
        .calib_memory_select_n(adc_spi_if_i.calib_memory_select_n),
        .sclk(adc_spi_if_i.sclk), .mosi(adc_spi_if_i.mosi), .dout(adc_spi_if_i.dout),
        .dout_en_n(adc_spi_if_i.dout_en_n));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // slave takes address and data at the same edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        @(posedge clk iff (awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        @(posedge clk iff bvalid);
        r = bresp;
        bready <= 1'b0;
        // an edge passes so a following call never drives bready twice in one step
        @(posedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        @(posedge clk iff arready);
        arvalid <= 1'b0;
        @(posedge clk iff rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_rd
    // cycles from one conversion end to the next
    task automatic period(output int n);
        @(posedge clk iff conv_done);
        n = 1;
        @(posedge clk);
        while (conv_done !== 1'b1) begin
            n++;
            @(posedge clk);
        end
    endtask : period
    // busy rises with the response; a few cycles still pass before polling
    task automatic run(input logic [31:0] op);
        axi_wr(OFS_CTRL, op);
        repeat (4) @(posedge clk);
        d = 32'h1;
        while (d[0] !== 1'b0) axi_rd(OFS_STATUS);
    endtask : run
    task automatic wrap_up;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #400us;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("cfg_regs", cfg_regs, 32'h0000_0400);
        axi_rd(OFS_CFG1);
        check("cfg1", d, 32'h0000_0004);
        axi_rd(8'h20);
        check("rresp", r, RESP_SLVERR);
        axi_wr(8'h20, 32'h0);
        check("bresp", r, RESP_SLVERR);
        axi_wr(OFS_CALIB, 32'h0040_840A);
        run(32'h1);
        check("cfg_regs", cfg_regs, 32'h0040_840A);
        axi_wr(OFS_CFG1, 32'hC4);
        run(32'h4);
        check("cfg_regs", cfg_regs, 32'h0040_C40A);
        repeat (2) @(posedge clk iff conv_done);
        period(n_cyc);
        check("period", n_cyc, PERIOD_NORMAL);
        run(32'h2);
        axi_rd(OFS_PRESSURE);
        check("pressure", d, {8'h00, P1});
        pressure_in <= P2;
        repeat (2) @(posedge clk iff conv_done);
        axi_wr(OFS_CFG1, 32'hD6);
        run(32'h4);
        axi_rd(OFS_PRESSURE);
        check("pressure", d, {8'h00, P2});
        repeat (2) @(posedge clk iff conv_done);
        period(n_cyc);
        check("period", n_cyc, PERIOD_FAST);
        run(32'h2);
        axi_rd(OFS_TEMPERATURE);
        check("temperature", d, {8'h00, temperature_in, 10'h000});
        axi_rd(OFS_STATUS);
        check("source", d[4], 1'b1);
        check("both", d[3], 1'b1);
        wrap_up();
    end
endmodule : tb_sensor_adc_spi_command_port
